// *** rtl/csio_pkg.sv ***
//=============================================
// notes
// Notes on behaviour
// - command byte encodes to class bits 6-7
// - key stays in bits 0-3, byte-0 parity
// - byte boundary complemented for read backward
// - corrected byte boundary loads count bits 45-47
// - duplex puts processor id in 37-38
// - formation starts once command word present
// - read: store word 0, clear word 1
// - read: set initial selection, copy address
// - ending frees channel, processor stays held
// - request plus write class sets outstanding
// - outstanding: store, end, mark resume, free
// - subchannels served, then channel resumes fetch
// - prefetch via storage controller advance strobe
// - prefetch: start selection, address plus 8
// - fetch error: refetch and data check
// - data check suppresses command chaining
// - clean prefetch: ending, clear data-required
// - start line arms selected, selection sets it
// - subchannel clock steps while start active
// - A1 reset, A2 load address, A3 stop
// - address out, select out, await operational in
// - command out, status, zero status releases 00
// - nonzero status: status store, code 01
// - select in returned: no selection, code 11
package csio_pkg;

  //=============================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CCW_HI = 8'h04;
  localparam logic [7:0] ADDR_CCW_LO = 8'h08;
  localparam logic [7:0] ADDR_KEY = 8'h0C;
  localparam logic [7:0] ADDR_DEV = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_UCW0_HI = 8'h18;
  localparam logic [7:0] ADDR_UCW0_LO = 8'h1C;
  localparam logic [7:0] ADDR_UCW1_HI = 8'h20;
  localparam logic [7:0] ADDR_UCW1_LO = 8'h24;
  localparam logic [7:0] ADDR_CSW = 8'h28;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DUPLEX_BIT = 1;
  localparam int CTRL_CPUID_LSB = 2;

  //=============================================
  // control word fields, bit 0 is the most significant
  localparam int UCW_KEY_FIRST = 0;
  localparam int UCW_KEY_LAST = 3;
  localparam int UCW_OP_FIRST = 6;
  localparam int UCW_OP_LAST = 7;
  localparam int UCW_ADDR_FIRST = 8;
  localparam int UCW_ADDR_LAST = 31;
  localparam int UCW_DAB_FIRST = 29;
  localparam int UCW_DAB_LAST = 31;
  localparam int UCW_CHAIN_CMD_BIT = 33;
  localparam int UCW_CPUID_FIRST = 37;
  localparam int UCW_CPUID_LAST = 38;
  localparam int UCW_DCHK_BIT = 39;
  localparam int UCW_CNT_FIRST = 45;
  localparam int UCW_CNT_LAST = 47;

  localparam logic [23:0] ADDR_STEP = 24'h000008;
  localparam logic [7:0] PARITY_ONLY = 8'hFF;
  localparam logic [63:0] WORD_RESET = 64'h0000000000000000;

  typedef enum logic [1:0] {
    OP_IDLE = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2,
    OP_RDBK = 2'h3
  } csio_op_t;

  localparam logic [1:0] CC_OK = 2'h0;
  localparam logic [1:0] CC_CSW = 2'h1;
  localparam logic [1:0] CC_NOSEL = 2'h3;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_FORM = 3'h1,
    M_STORE = 3'h3,
    M_BREAK = 3'h2,
    M_FETCH = 3'h6,
    M_WAITSEL = 3'h7
  } csio_main_t;

  typedef enum logic [3:0] {
    S_OFF = 4'h0,
    S_CLK = 4'h1,
    S_ADRO = 4'h3,
    S_SELO = 4'h2,
    S_ADRIN = 4'h6,
    S_CMDO = 4'h7,
    S_STAT = 4'h5,
    S_SVC = 4'h4,
    S_END = 4'hC
  } csio_sub_t;

  localparam logic [1:0] PH_A1 = 2'h1;
  localparam logic [1:0] PH_A2 = 2'h2;
  localparam logic [1:0] PH_A3 = 2'h3;

  typedef struct packed {
    logic address_out;
    logic select_out;
    logic command_out;
    logic service_out;
  } csio_tags_out_t;

  typedef struct packed {
    logic operational_in;
    logic address_in;
    logic status_in;
    logic select_in;
  } csio_tags_in_t;

  // sense shares the read class; control shares write
  function automatic csio_op_t op_encode(input logic [0:7] cmd);
    if (cmd[4:7] == 4'hC) begin
      return OP_RDBK;
    end else if (cmd[4:7] == 4'h4 || cmd[6:7] == 2'h2) begin
      return OP_READ;
    end else if (cmd[7]) begin
      return OP_WRITE;
    end else begin
      return OP_IDLE;
    end
  endfunction

endpackage

// *** rtl/csio_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module csio_top
  import csio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sub_prio_req,
  output logic o_fetch_req,
  output logic [23:0] o_fetch_addr,
  output logic [3:0] o_fetch_key,
  input wire logic i_fetch_advance,
  input wire logic [63:0] i_fetch_data,
  input wire logic i_fetch_error,
  output logic [8:0] o_bus_out,
  output csio_tags_out_t o_tags,
  input wire logic [7:0] i_bus_in,
  input wire csio_tags_in_t i_tags,
  output logic o_main_busy,
  output logic o_ending,
  output logic o_cpu_hold,
  output logic o_release,
  output logic [1:0] o_cond_code,
  output logic o_csw_store,
  output logic o_chain_suppress
);

  //=============================================
  // state
  csio_main_t mstate;
  csio_sub_t sstate;
  logic [1:0] sc_phase;
  logic [0:63] channel_command_word;
  logic [0:63] ucw0;
  logic [0:63] ucw1;
  logic [7:0] ucw1_par;
  logic ucw0_p0;
  logic [3:0] caw_key;
  logic [7:0] initial_unit_address_register;
  logic [7:0] unit_address_register;
  logic [2:0] dab_reg;
  logic [7:0] csw_status;
  logic duplex;
  logic [1:0] cpu_id;
  logic outstanding;
  logic data_required;
  logic refetch;
  logic init_sel;
  logic sc_selected;
  logic isel_latch;
  logic sel_busy;
  logic start_req;
  logic apb_done;
  logic [31:0] next_prdata;
  logic next_slverr;
  csio_op_t op;
  logic [2:0] next_dab;

  assign apb_done = i_psel & i_penable & o_pready;
  assign op = csio_op_t'(ucw0[UCW_OP_FIRST:UCW_OP_LAST]);
  assign next_dab = (op == OP_RDBK) ? ~ucw0[UCW_DAB_FIRST:UCW_DAB_LAST] : ucw0[UCW_DAB_FIRST:UCW_DAB_LAST];

  //=============================================
  // apb slave, one wait state on every access
  always_comb begin
    next_prdata = 32'h00000000;
    next_slverr = 1'b0;
    case (i_paddr)
      ADDR_CTRL: next_prdata = {28'h0000000, cpu_id, duplex, 1'b0};
      ADDR_CCW_HI: next_prdata = channel_command_word[0:31];
      ADDR_CCW_LO: next_prdata = channel_command_word[32:63];
      ADDR_KEY: next_prdata = {28'h0000000, caw_key};
      ADDR_DEV: next_prdata = {24'h000000, initial_unit_address_register};
      ADDR_STATUS: next_prdata = {16'h0000, sstate, 1'b0, mstate, o_cond_code, refetch, data_required,
                                  outstanding, o_cpu_hold, o_main_busy, ucw0_p0};
      ADDR_UCW0_HI: next_prdata = ucw0[0:31];
      ADDR_UCW0_LO: next_prdata = ucw0[32:63];
      ADDR_UCW1_HI: next_prdata = ucw1[0:31];
      ADDR_UCW1_LO: next_prdata = ucw1[32:63];
      ADDR_CSW: next_prdata = {24'h000000, csw_status};
      default: next_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      o_prdata <= (i_psel & ~i_pwrite) ? next_prdata : 32'h00000000;
      o_pslverr <= i_psel & i_penable & ~o_pready & next_slverr;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      channel_command_word <= WORD_RESET;
      caw_key <= 4'h0;
      initial_unit_address_register <= 8'h00;
      duplex <= 1'b0;
      cpu_id <= 2'h0;
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (apb_done && i_pwrite) begin
        case (i_paddr)
          ADDR_CTRL: begin
            duplex <= i_pwdata[CTRL_DUPLEX_BIT];
            cpu_id <= i_pwdata[CTRL_CPUID_LSB +: 2];
            start_req <= i_pwdata[CTRL_START_BIT] & (mstate == M_IDLE) & ~o_cpu_hold;
          end
          ADDR_CCW_HI: channel_command_word[0:31] <= i_pwdata;
          ADDR_CCW_LO: channel_command_word[32:63] <= i_pwdata;
          ADDR_KEY: caw_key <= i_pwdata[3:0];
          ADDR_DEV: initial_unit_address_register <= i_pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  //=============================================
  // main channel sequence
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mstate <= M_IDLE;
      o_main_busy <= 1'b0;
      o_ending <= 1'b0;
      o_cpu_hold <= 1'b0;
      outstanding <= 1'b0;
      data_required <= 1'b0;
      refetch <= 1'b0;
      init_sel <= 1'b0;
      o_fetch_req <= 1'b0;
    end else begin
      o_ending <= 1'b0;
      case (mstate)
        M_IDLE: begin
          if (start_req) begin
            // command word in channel, fetch no longer required
            mstate <= M_FORM;
            o_main_busy <= 1'b1;
            o_cpu_hold <= 1'b1;
            refetch <= 1'b0;
          end
        end
        M_FORM: begin
          outstanding <= i_sub_prio_req & (op == OP_WRITE);
          if (op != OP_WRITE) begin
            mstate <= M_STORE;
          end else if (i_sub_prio_req) begin
            mstate <= M_BREAK;
            o_ending <= 1'b1;
            data_required <= 1'b1;
            o_main_busy <= 1'b0;
          end else begin
            mstate <= M_FETCH;
            o_fetch_req <= 1'b1;
          end
        end
        M_STORE: begin
          init_sel <= 1'b1;
          o_ending <= 1'b1;
          o_main_busy <= 1'b0;
          mstate <= M_WAITSEL;
        end
        M_BREAK: begin
          // channel regains priority only once no subchannel asks
          if (!i_sub_prio_req) begin
            o_main_busy <= 1'b1;
            outstanding <= 1'b0;
            o_fetch_req <= 1'b1;
            mstate <= M_FETCH;
          end
        end
        M_FETCH: begin
          if (i_fetch_advance) begin
            o_fetch_req <= 1'b0;
            init_sel <= 1'b1;
            refetch <= i_fetch_error;
            o_ending <= 1'b1;
            data_required <= 1'b0;
            o_main_busy <= 1'b0;
            mstate <= M_WAITSEL;
          end
        end
        M_WAITSEL: begin
          if (o_release) begin
            init_sel <= 1'b0;
            o_cpu_hold <= 1'b0;
            mstate <= M_IDLE;
          end
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end

  //=============================================
  // subchannel control words
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ucw0 <= WORD_RESET;
      ucw1 <= WORD_RESET;
      ucw1_par <= PARITY_ONLY;
      ucw0_p0 <= 1'b1;
      dab_reg <= 3'h0;
      o_fetch_addr <= 24'h000000;
      o_fetch_key <= 4'h0;
    end else begin
      if (mstate == M_IDLE && start_req) begin
        ucw0 <= channel_command_word;
        ucw0[UCW_KEY_FIRST:UCW_KEY_LAST] <= caw_key;
        ucw0[4:5] <= 2'h0;
        ucw0[UCW_OP_FIRST:UCW_OP_LAST] <= op_encode(channel_command_word[0:7]);
        ucw0[UCW_DCHK_BIT] <= 1'b0;
        ucw0_p0 <= ~^{caw_key, 2'h0, op_encode(channel_command_word[0:7])};
      end
      if (mstate == M_FORM) begin
        dab_reg <= next_dab;
        ucw0[UCW_CNT_FIRST:UCW_CNT_LAST] <= next_dab;
        if (op == OP_RDBK) begin
          ucw0[UCW_DAB_FIRST:UCW_DAB_LAST] <= next_dab;
        end
        if (duplex) begin
          ucw0[UCW_CPUID_FIRST:UCW_CPUID_LAST] <= cpu_id;
        end
        o_fetch_addr <= ucw0[UCW_ADDR_FIRST:UCW_ADDR_LAST];
        o_fetch_key <= ucw0[UCW_KEY_FIRST:UCW_KEY_LAST];
      end
      if (mstate == M_STORE) begin
        // block line: word 1 comes back as parity bits only
        ucw1 <= WORD_RESET;
        ucw1_par <= PARITY_ONLY;
      end
      if (mstate == M_FETCH && i_fetch_advance) begin
        ucw1 <= i_fetch_data;
        ucw0[UCW_ADDR_FIRST:UCW_ADDR_LAST] <= ucw0[UCW_ADDR_FIRST:UCW_ADDR_LAST] + ADDR_STEP;
        if (i_fetch_error) begin
          ucw0[UCW_DCHK_BIT] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_chain_suppress <= 1'b0;
    end else begin
      o_chain_suppress <= ucw0[UCW_DCHK_BIT] & ucw0[UCW_CHAIN_CMD_BIT];
    end
  end

  //=============================================
  // multiplex subchannel selection
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sc_selected <= 1'b0;
    end else if (!o_cpu_hold) begin
      sc_selected <= 1'b0;
    end else if (init_sel) begin
      sc_selected <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sstate <= S_OFF;
      sc_phase <= 2'h0;
      unit_address_register <= 8'h00;
      isel_latch <= 1'b0;
      sel_busy <= 1'b0;
      o_bus_out <= 9'h000;
      o_tags <= '0;
      o_release <= 1'b0;
      o_cond_code <= CC_OK;
      o_csw_store <= 1'b0;
      csw_status <= 8'h00;
    end else begin
      o_release <= 1'b0;
      o_csw_store <= 1'b0;
      case (sstate)
        S_OFF: begin
          if (sc_selected && !sel_busy) begin
            sstate <= S_CLK;
            sc_phase <= PH_A1;
          end
        end
        S_CLK: begin
          // the clock only steps while selected stays up
          if (!sc_selected) begin
            sstate <= S_OFF;
            sc_phase <= 2'h0;
          end else begin
            sc_phase <= sc_phase + 2'h1;
            case (sc_phase)
              PH_A1: begin
                o_tags <= '0;
                o_bus_out <= 9'h000;
                isel_latch <= 1'b0;
              end
              PH_A2: unit_address_register <= initial_unit_address_register;
              PH_A3: begin
                isel_latch <= 1'b1;
                sel_busy <= 1'b1;
                sc_phase <= 2'h0;
                o_bus_out <= {~^unit_address_register, unit_address_register};
                o_tags.address_out <= 1'b1;
                sstate <= S_ADRO;
              end
              default: sc_phase <= PH_A1;
            endcase
          end
        end
        S_ADRO: begin
          o_tags.select_out <= 1'b1;
          sstate <= S_SELO;
        end
        S_SELO: begin
          if (i_tags.select_in && !i_tags.operational_in) begin
            o_tags <= '0;
            o_cond_code <= CC_NOSEL;
            o_release <= 1'b1;
            sstate <= S_END;
          end else if (i_tags.operational_in) begin
            o_tags.address_out <= 1'b0;
            o_bus_out <= 9'h000;
            sstate <= S_ADRIN;
          end
        end
        S_ADRIN: begin
          if (i_tags.address_in) begin
            o_tags.select_out <= 1'b0;
            if (i_bus_in == unit_address_register) begin
              // word 0 byte 0 now holds key and class, so the raw command goes out
              o_bus_out <= {~^channel_command_word[0:7], channel_command_word[0:7]};
              o_tags.command_out <= 1'b1;
              sstate <= S_CMDO;
            end else begin
              o_csw_store <= 1'b1;
              o_cond_code <= CC_CSW;
              o_release <= 1'b1;
              sstate <= S_END;
            end
          end
        end
        S_CMDO: begin
          if (!i_tags.address_in) begin
            o_tags.command_out <= 1'b0;
            o_bus_out <= 9'h000;
            sstate <= S_STAT;
          end
        end
        S_STAT: begin
          if (i_tags.status_in) begin
            csw_status <= i_bus_in;
            o_release <= 1'b1;
            if (i_bus_in == 8'h00) begin
              o_tags.service_out <= 1'b1;
              o_cond_code <= CC_OK;
              sstate <= S_SVC;
            end else begin
              o_csw_store <= 1'b1;
              o_cond_code <= CC_CSW;
              sstate <= S_END;
            end
          end
        end
        S_SVC: begin
          if (!i_tags.status_in) begin
            o_tags.service_out <= 1'b0;
            sstate <= S_END;
          end
        end
        S_END: begin
          isel_latch <= 1'b0;
          if (!o_cpu_hold) begin
            sel_busy <= 1'b0;
            o_tags <= '0;
            sstate <= S_OFF;
          end
        end
        default: sstate <= S_OFF;
      endcase
    end
  end

  //=============================================
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  chk_op_encode: assert property ((mstate == M_IDLE && start_req) |=>
    ucw0[UCW_OP_FIRST:UCW_OP_LAST] == op_encode($past(channel_command_word[0:7])))
    else $error("operation class not encoded from command byte");

  chk_key_keep: assert property ((mstate == M_IDLE && start_req) |=>
    ucw0[UCW_KEY_FIRST:UCW_KEY_LAST] == $past(caw_key) && ucw0_p0 == ~^ucw0[0:7])
    else $error("key or byte 0 parity wrong");

  chk_dab_count: assert property ((mstate == M_FORM) |=>
    ucw0[UCW_CNT_FIRST:UCW_CNT_LAST] == dab_reg &&
    dab_reg == ($past(op) == OP_RDBK ? ~$past(ucw0[UCW_DAB_FIRST:UCW_DAB_LAST]) :
                $past(ucw0[UCW_DAB_FIRST:UCW_DAB_LAST])))
    else $error("byte count not loaded from corrected boundary");

  chk_read_clear: assert property ((mstate == M_STORE) |=>
    ucw1 == WORD_RESET && init_sel && o_ending && !o_main_busy ##1 o_cpu_hold)
    else $error("read setup did not clear word 1 or start selection");

  chk_outst_write: assert property (outstanding |-> op == OP_WRITE)
    else $error("outstanding set for a non-write class");

  chk_break_free: assert property ((mstate == M_BREAK) |->
    !o_main_busy && data_required && !o_fetch_req)
    else $error("break-in without freeing main channel");

  chk_addr_step: assert property ((mstate == M_FETCH && i_fetch_advance) |=>
    ucw0[UCW_ADDR_FIRST:UCW_ADDR_LAST] == $past(ucw0[UCW_ADDR_FIRST:UCW_ADDR_LAST]) + ADDR_STEP &&
    init_sel && !data_required)
    else $error("prefetch did not step data address by 8");

  chk_fetch_err: assert property ((mstate == M_FETCH && i_fetch_advance && i_fetch_error) |=>
    refetch && ucw0[UCW_DCHK_BIT] ##1 o_chain_suppress == ucw0[UCW_CHAIN_CMD_BIT])
    else $error("fetch error not recorded as data check");

  chk_a3_stop: assert property ((sstate == S_CLK && sc_phase == PH_A3 && sc_selected) |=>
    sel_busy && isel_latch && o_tags.address_out && o_bus_out[7:0] == unit_address_register ##1 o_tags.select_out)
    else $error("first subchannel cycle did not end in address out");

  chk_nosel_code: assert property ((sstate == S_SELO && i_tags.select_in && !i_tags.operational_in) |=>
    o_release && o_cond_code == CC_NOSEL && !o_tags.select_out)
    else $error("no selection not released with code 11");

endmodule
`default_nettype wire

// *** verification/csio_cu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
//==========
// control unit on the channel interface
module csio_cu_model
  import csio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_my_addr,
  input wire logic [7:0] i_status,
  input wire logic [2:0] i_lag,
  input wire logic [8:0] i_bus_out,
  input wire csio_tags_out_t i_tags,
  output logic [7:0] o_bus_in,
  output var csio_tags_in_t o_tags
);
  logic [2:0] ph;
  logic [2:0] cnt;
  logic [7:0] seen;
  // released bus shows the inverse, so a stale byte never matches
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_tags <= '0;
      o_bus_in <= 8'h5A;
      ph <= 3'h0;
      cnt <= 3'h0;
      seen <= 8'h00;
    end else begin
      cnt <= cnt + 3'h1;
      case (ph)
        3'h0: begin
          if (i_tags.address_out) begin
            seen <= i_bus_out[7:0];
          end
          if (!i_tags.select_out) begin
            o_tags.select_in <= 1'h0;
          end else if (seen == i_my_addr) begin
            o_tags.operational_in <= 1'h1;
            ph <= 3'h1;
            cnt <= 3'h0;
          end else begin
            o_tags.select_in <= 1'h1;
          end
        end
        3'h1: if (!i_tags.address_out && cnt >= i_lag) begin
          o_bus_in <= i_my_addr;
          o_tags.address_in <= 1'h1;
          ph <= 3'h2;
        end
        3'h2: if (i_tags.command_out) begin
          o_tags.address_in <= 1'h0;
          o_bus_in <= ~o_bus_in;
          ph <= 3'h3;
          cnt <= 3'h0;
        end
        3'h3: if (!i_tags.command_out && cnt >= i_lag) begin
          o_bus_in <= i_status;
          o_tags.status_in <= 1'h1;
          ph <= 3'h4;
        end
        3'h4: if (i_tags.service_out) begin
          o_tags.status_in <= 1'h0;
          o_bus_in <= ~o_bus_in;
          ph <= 3'h5;
        end
        default: if (!i_tags.service_out) begin
          o_tags.operational_in <= 1'h0;
          ph <= 3'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verification/csio_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module csio_top_tb
  import csio_pkg::*;
;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sub_req = 1'h0, adv = 1'h0, ferr = 1'h0;
  logic [7:0] paddr = 8'h00, bus_in, cu_stat = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [63:0] fdata = 64'h0;
  logic [2:0] lag = 3'h0;
  logic pready, pslverr, serr, freq, busy, ending, hold, rel, channel_status_word, chs, hold_end, busy_end, early;
  logic [23:0] faddr;
  logic [3:0] fkey;
  logic [8:0] bus_out, adr_seen, cmd_seen;
  logic [1:0] cc, cc_seen;
  csio_tags_out_t tags_o;
  csio_tags_in_t tags_i;
  int n_end, n_csw, errors = 0, compares = 0;

  always #5 i_clk = ~i_clk;

  csio_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sub_prio_req(sub_req), .o_fetch_req(freq), .o_fetch_addr(faddr),
    .o_fetch_key(fkey), .i_fetch_advance(adv), .i_fetch_data(fdata), .i_fetch_error(ferr),
    .o_bus_out(bus_out), .o_tags(tags_o), .i_bus_in(bus_in), .i_tags(tags_i), .o_main_busy(busy),
    .o_ending(ending), .o_cpu_hold(hold), .o_release(rel), .o_cond_code(cc), .o_csw_store(channel_status_word),
    .o_chain_suppress(chs));

  csio_cu_model cu (.i_clk(i_clk), .i_reset(i_reset), .i_my_addr(8'h35), .i_status(cu_stat),
    .i_lag(lag), .i_bus_out(bus_out), .i_tags(tags_o), .o_bus_in(bus_in), .o_tags(tags_i));

  //==========
  // interface watch
  always @(posedge i_clk) begin
    if (tags_o.address_out) adr_seen <= bus_out;
    if (tags_o.command_out) cmd_seen <= bus_out;
    if (ending) begin
      n_end <= n_end + 1;
      hold_end <= hold;
      busy_end <= busy;
    end
    if (channel_status_word) n_csw <= n_csw + 1;
    if (freq && sub_req) early <= 1'h1;
  end

  //==========
  // helpers
  task conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string n, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'h1;
    @(posedge i_clk);
    while (pready !== 1'h1) @(posedge i_clk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rst;
    @(posedge i_clk);
    i_reset <= 1'h1;
    @(posedge i_clk);
    i_reset <= 1'h0;
    n_end = 0;
    n_csw = 0;
    early = 1'h0;
  endtask

  task sio(input logic [7:0] c, input logic [23:0] a, input logic [31:0] lo, input logic [7:0] dev,
    input logic [31:0] ctl);
    rst;
    apb(1'h1, ADDR_KEY, 32'hA);
    apb(1'h1, ADDR_DEV, {24'h0, dev});
    apb(1'h1, ADDR_CCW_HI, {c, a});
    apb(1'h1, ADDR_CCW_LO, lo);
    apb(1'h1, ADDR_CTRL, ctl);
  endtask

  // waits on the release pulse; the watchdog bounds a hang
  task wrel;
    while (rel !== 1'h1) @(posedge i_clk);
    cc_seen = cc;
    repeat (3) @(posedge i_clk);
    chk("hold", hold, 1'h0);
  endtask

  task ucw0(input logic [1:0] op, input logic [23:0] a, input logic [2:0] n);
    apb(1'h0, ADDR_UCW0_HI, 32'h0);
    chk("key", rd[31:28], 4'hA);
    chk("class", rd[25:24], op);
    chk("address", rd[23:0], a);
    apb(1'h0, ADDR_UCW0_LO, 32'h0);
    chk("count", rd[18:16], n);
  endtask

  task feed(input logic e, input logic [63:0] d, input int wt, input logic [27:0] ka);
    while (freq !== 1'h1) @(posedge i_clk);
    chk("fetch", {fkey, faddr}, ka);
    repeat (wt) @(posedge i_clk);
    adv <= 1'h1;
    ferr <= e;
    fdata <= d;
    @(posedge i_clk);
    adv <= 1'h0;
    ferr <= 1'h0;
    fdata <= ~d;
  endtask

  //==========
  // scenarios
  task t_regs;
    rst;
    apb(1'h1, 8'h2C, 32'hFFFFFFFF);
    chk("slverr", serr, 1'h1);
    apb(1'h0, 8'h2C, 32'h0);
    chk("unmapped", {serr, rd}, {1'h1, 32'h0});
    apb(1'h1, ADDR_KEY, 32'h5);
    apb(1'h0, ADDR_KEY, 32'h0);
    chk("key reg", rd[3:0], 4'h5);
    $display("test regs done");
  endtask

  task t_read;
    sio(8'h02, 24'h001235, 32'h10, 8'h35, 32'h1);
    wrel;
    chk("code", cc_seen, CC_OK);
    chk("addr out", adr_seen, {~^8'h35, 8'h35});
    chk("cmd out", cmd_seen, {~^8'h02, 8'h02});
    chk("ending", {hold_end, busy_end}, 2'h2);
    chk("endings", n_end, 1);
    ucw0(2'h2, 24'h001235, 3'h5);
    apb(1'h0, ADDR_UCW1_HI, 32'h0);
    chk("word 1", rd, 32'h0);
    $display("test read done");
  endtask

  task t_rdbk;
    cu_stat <= 8'h0C;
    sub_req <= 1'h1;
    sio(8'h0C, 24'h000105, 32'h10, 8'h35, 32'hB);
    wrel;
    chk("code", cc_seen, CC_CSW);
    chk("stores", n_csw, 1);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk("outstanding", {rd[3], early}, 2'h0);
    sub_req <= 1'h0;
    ucw0(2'h3, 24'h000102, 3'h2);
    chk("cpu id", rd[26:25], 2'h2);
    cu_stat <= 8'h00;
    $display("test read backward done");
  endtask

  task t_nosel;
    sio(8'h02, 24'h0, 32'h10, 8'h36, 32'h1);
    wrel;
    chk("code", cc_seen, CC_NOSEL);
    chk("stores", n_csw, 0);
    $display("test no selection done");
  endtask

  task t_wbrk;
    sub_req <= 1'h1;
    sio(8'h01, 24'h002000, 32'h40000010, 8'h35, 32'h1);
    while (ending !== 1'h1) @(posedge i_clk);
    chk("busy", busy, 1'h0);
    repeat (10) @(posedge i_clk);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk("break", {rd[4:3], freq, early}, 4'hC);
    sub_req <= 1'h0;
    feed(1'h1, 64'h0123456789ABCDEF, 0, {4'hA, 24'h002000});
    wrel;
    chk("code", cc_seen, CC_OK);
    chk("chain", chs, 1'h1);
    ucw0(2'h1, 24'h002008, 3'h0);
    chk("data check", rd[24], 1'h1);
    apb(1'h0, ADDR_UCW1_HI, 32'h0);
    chk("word 1", rd, 32'h01234567);
    $display("test write break-in done");
  endtask

  task t_write;
    lag <= 3'h5;
    sio(8'h01, 24'h0FFFFB, 32'h10, 8'h35, 32'h1);
    feed(1'h0, 64'hFEDCBA9876543210, 6, {4'hA, 24'h0FFFFB});
    wrel;
    chk("code", cc_seen, CC_OK);
    chk("endings", n_end, 1);
    chk("ending", {hold_end, busy_end, chs}, 3'h4);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk("data req", rd[4], 1'h0);
    ucw0(2'h1, 24'h100003, 3'h3);
    chk("data check", rd[24], 1'h0);
    apb(1'h0, ADDR_UCW1_LO, 32'h0);
    chk("word 1", rd, 32'h76543210);
    lag <= 3'h0;
    $display("test write done");
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    conclude;
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'h0;
    t_regs;
    t_read;
    t_rdbk;
    t_nosel;
    t_wbrk;
    t_write;
    conclude;
  end
endmodule
`default_nettype wire
